/* core/rx_reasm_pkg.sv */
/*
  shared constants and types for the receive reassembly control block.
  assumes a 16-bit register port, 21-bit external byte addresses and 9-bit memory bytes.
*/
package rx_reasm_pkg;

  // register offsets on the 16-bit register port
  localparam logic [15:0] REG_CTRL = 16'h3000;
  localparam logic [15:0] REG_SH_ID = 16'h3010;
  localparam logic [15:0] REG_SH_CNT = 16'h3012;
  localparam logic [15:0] REG_UN_ID = 16'h3020;
  localparam logic [15:0] REG_UN_CNT = 16'h3022;
  localparam logic [15:0] REG_OV_ID = 16'h3030;
  localparam logic [15:0] REG_OV_CNT = 16'h3032;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // control register fields
  localparam int CTRL_BASE_LSB = 0;
  localparam int CTRL_BASE_MSB = 2;
  localparam int CTRL_EN_LSB = 4;
  localparam int CTRL_EN_MSB = 8;

  // shared error kinds, bit index in the enable field
  localparam int ERR_HDR_PAR = 0;
  localparam int ERR_HDR_CRC = 1;
  localparam int ERR_SEQ = 2;
  localparam int ERR_PB_PAR = 3;
  localparam int ERR_PB_RANGE = 4;
  localparam int NUM_SHARED_ERR = 5;

  // control structure word indices
  localparam int W_ENTRY = 0;
  localparam int W_LEAD = 1;
  localparam int W_AVG = 2;
  localparam int W_CUR = 3;
  localparam int W_RDPOS = 4;
  localparam int W_STATE = 5;
  localparam int STRUCT_WORDS = 6;
  localparam int S_BIT = 15;
  localparam int BS_MSB = 14;
  localparam int BS_LSB = 12;
  localparam int V_BIT = 15;

  // adaptation type codes
  localparam logic [1:0] AS_CBR = 2'h0;
  localparam logic [1:0] AS_AAL1 = 2'h2;
  localparam logic [1:0] AS_SRTS = 2'h3;

  // buffer size codes
  localparam logic [2:0] BS_64 = 3'h0;
  localparam logic [2:0] BS_128 = 3'h1;
  localparam logic [2:0] BS_256 = 3'h2;
  localparam logic [2:0] BS_512 = 3'h3;
  localparam logic [2:0] BS_1024 = 3'h4;

  localparam logic [6:0] CELL_BYTES = 7'h30;
  localparam logic [5:0] PAYLOAD_FULL = 6'h2F;
  localparam logic [5:0] PAYLOAD_MIN = 6'h03;
  localparam logic [7:0] SILENCE = 8'hFF;
  localparam logic [6:0] PB_MAX_OFFSET = 7'h5D;
  localparam logic [3:0] STRUCT_LOW = 4'h0;
  localparam logic [1:0] LEAD_LOW = 2'h0;
  localparam logic [20:0] WORD_STEP = 21'h000002;
  localparam logic [7:0] ENTRY_STEP = 8'h02;

  typedef struct packed {
    logic sop;
    logic [13:0] vc_field;
    logic [7:0] data;
  } cell_beat_type;

  typedef struct packed {
    logic req;
    logic we;
    logic byte_access;
    logic [20:0] addr;
    logic [15:0] wdata;
  } mem_cmd_type;

endpackage

/* core/aal_rx_reassembly_buffer_ctrl.sv */
/*
  receive reassembly control: cell fifo, structure load, lead window check,
  header checks, payload scatter into circular buffers, tdm read-out service.
  assumes cells arrive as 48 payload beats with sop on the first, and a
  memory command held until mem_ack after any number of wait cycles, with read data valid in the ack cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module rx_cell_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  wire logic full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire logic empty = (wr_r == rd_r);
  wire logic push = in_valid && !full;
  wire logic pop = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule // rx_cell_fifo

module aal_rx_reassembly_buffer_ctrl
  import rx_reasm_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire cell_beat_type cell_in,
  input wire logic cell_valid,
  output logic cell_ready,
  output mem_cmd_type mem_cmd,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic tdm_req,
  input wire logic [20:0] tdm_addr,
  input wire logic tdm_underrun_en,
  input wire logic tdm_wb_dis,
  output logic tdm_ack,
  output logic [7:0] tdm_data,
  output logic tdm_underrun
);

  typedef enum logic [8:0] {
    ST_IDLE = 9'b000000001,
    ST_LOAD = 9'b000000010,
    ST_CHK = 9'b000000100,
    ST_PAY = 9'b000001000,
    ST_ENT = 9'b000010000,
    ST_BYTE = 9'b000100000,
    ST_WB = 9'b001000000,
    ST_TRD = 9'b010000000,
    ST_TWB = 9'b100000000
  } state_type;

  function automatic logic [2:0] crc3(input logic [3:0] d);
    logic [2:0] r;
    logic fb;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      fb = d[i] ^ r[2];
      r = {r[1], r[0] ^ fb, fb};
    end
    return r;
  endfunction

  state_type state_r;
  logic [15:0] ctrl_r;
  logic [15:0] sh_id_r, sh_cnt_r, un_id_r, un_cnt_r, ov_id_r, ov_cnt_r;
  logic [15:0] sw_r [STRUCT_WORDS];
  logic [13:0] vc_r;
  logic [2:0] ld_idx_r;
  logic [6:0] k_r;
  logic [7:0] cur_r;
  logic [9:0] wp_r;
  logic [7:0] hdr_r;
  logic hdr_seen_r;
  logic pb_exp_r;
  logic [15:0] ent_r;
  logic wb_idx_r;
  logic [20:0] taddr_r;
  logic tue_r, twd_r;
  logic [8:0] tbyte_r;

  cell_beat_type f_data;
  logic f_valid;
  logic f_pop;

  rx_cell_fifo #(.WIDTH($bits(cell_beat_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(cell_valid),
    .in_ready(cell_ready),
    .in_data(cell_in),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // structure and buffer addressing
  wire logic [2:0] region_base = ctrl_r[CTRL_BASE_MSB:CTRL_BASE_LSB];
  wire logic [4:0] err_en = ctrl_r[CTRL_EN_MSB:CTRL_EN_LSB];
  wire logic [20:0] struct_ptr = {region_base, vc_r, STRUCT_LOW};
  wire logic [20:0] ld_addr = struct_ptr + (WORD_STEP * 21'(ld_idx_r));
  wire logic [7:0] first_ent = sw_r[W_ENTRY][15:8];
  wire logic [7:0] last_ent = sw_r[W_ENTRY][7:0];
  wire logic [20:0] ent_addr = {struct_ptr[20:8], cur_r};
  wire logic [1:0] as_code = sw_r[W_AVG][7:6];
  wire logic [5:0] psize = sw_r[W_AVG][5:0];
  wire logic is_aal1 = (as_code == AS_AAL1) || (as_code == AS_SRTS);
  wire logic s_init = sw_r[W_STATE][S_BIT];
  wire logic [2:0] bs_code = sw_r[W_STATE][BS_MSB:BS_LSB];

  // reserved size codes fall back to the smallest buffer
  wire logic [9:0] size_mask =
    (bs_code == BS_128) ? 10'h07F :
    (bs_code == BS_256) ? 10'h0FF :
    (bs_code == BS_512) ? 10'h1FF :
    (bs_code == BS_1024) ? 10'h3FF : 10'h03F;

  wire logic [9:0] min4 = {sw_r[W_LEAD][15:8], LEAD_LOW};
  wire logic [9:0] max4 = {sw_r[W_LEAD][7:0], LEAD_LOW};
  wire logic [9:0] avg4 = {sw_r[W_AVG][15:8], LEAD_LOW};
  wire logic [9:0] rdpos = sw_r[W_RDPOS][9:0];
  wire logic [9:0] wp_old = sw_r[W_STATE][9:0];
  wire logic [9:0] lead = (wp_old - rdpos) & size_mask;
  wire logic overrun = s_init && (lead > max4);
  wire logic underrun = s_init && (lead < min4);
  wire logic [9:0] wp_avg = (rdpos + avg4) & size_mask;
  wire logic [9:0] wp_start = (!s_init || overrun || underrun) ? wp_avg : wp_old;

  // buffer byte address: buffers sit on boundaries of their own size
  wire logic [20:0] byte_addr = {ent_r[14:0], 6'h00} | {11'h000, wp_r & size_mask};
  wire logic ent_valid = ent_r[V_BIT];
  wire logic last_payload = (k_r == {1'b0, psize});
  wire logic last_beat = (k_r == CELL_BYTES - 7'h01);

  // header and pointer byte checks
  wire logic [7:0] hb = f_data.data;
  wire logic [2:0] sc_exp = sw_r[W_CUR][6:4] + 3'h1;
  wire logic at_hdr = is_aal1 && (k_r == 7'h00);
  wire logic at_pb = pb_exp_r && (k_r == 7'h01);
  wire logic hdr_par_err = ^hb;
  wire logic hdr_crc_err = (crc3(hb[7:4]) != hb[3:1]);
  wire logic seq_err = s_init && (hb[6:4] != sc_exp);
  wire logic pb_par_err = ^hb;
  wire logic pb_rng_err = (hb[6:0] > PB_MAX_OFFSET);
  wire logic pb_follows = hb[7] && !hb[4];
  wire logic beat_here = (state_r == ST_PAY) && f_valid;
  wire logic [4:0] err_vec = !beat_here ? 5'h00 :
    at_hdr ? {2'b00, seq_err, hdr_crc_err, hdr_par_err} :
    at_pb ? {pb_rng_err, pb_par_err, 3'b000} : 5'h00;
  wire logic [4:0] err_hit = err_vec & err_en;
  wire logic [2:0] err_n = 3'(err_hit[0]) + 3'(err_hit[1]) + 3'(err_hit[2])
    + 3'(err_hit[3]) + 3'(err_hit[4]);
  wire logic [15:0] vc_id = {2'b00, vc_r};
  wire logic in_payload = !at_hdr && !at_pb && (k_r <= {1'b0, psize});

  // fifo drain: stray beats in idle are dropped, but a sop beat stays for the payload pass;
  // header, pointer and spare beats pop at once, payload after its write
  assign f_pop = (state_r == ST_IDLE && !tdm_req && !f_data.sop)
    || (beat_here && !in_payload)
    || (state_r == ST_BYTE && (!ent_valid || mem_ack));

  // memory command
  wire logic [15:0] wb_word = wb_idx_r ? {1'b1, bs_code, 2'b00, wp_r} : {cur_r, hdr_r};
  wire logic [20:0] wb_addr = struct_ptr + (wb_idx_r ? WORD_STEP * 21'(W_STATE)
    : WORD_STEP * 21'(W_CUR));
  wire logic [8:0] tdm_wb = twd_r ? {1'b1, tbyte_r[7:0]} : {1'b1, SILENCE};
  assign mem_cmd.req = (state_r == ST_LOAD) || (state_r == ST_ENT) || (state_r == ST_WB)
    || (state_r == ST_TRD) || (state_r == ST_TWB) || (state_r == ST_BYTE && ent_valid);
  assign mem_cmd.we = (state_r == ST_BYTE) || (state_r == ST_WB) || (state_r == ST_TWB);
  assign mem_cmd.byte_access = (state_r == ST_BYTE) || (state_r == ST_TRD)
    || (state_r == ST_TWB);
  assign mem_cmd.addr = (state_r == ST_LOAD) ? ld_addr :
    (state_r == ST_ENT) ? ent_addr :
    (state_r == ST_BYTE) ? byte_addr :
    (state_r == ST_WB) ? wb_addr : taddr_r;
  assign mem_cmd.wdata = (state_r == ST_BYTE) ? {7'h00, 1'b0, f_data.data} :
    (state_r == ST_WB) ? wb_word : {7'h00, tdm_wb};

  wire logic [15:0] rd_mux =
    (reg_addr == REG_CTRL) ? ctrl_r :
    (reg_addr == REG_SH_ID) ? sh_id_r :
    (reg_addr == REG_SH_CNT) ? sh_cnt_r :
    (reg_addr == REG_UN_ID) ? un_id_r :
    (reg_addr == REG_UN_CNT) ? un_cnt_r :
    (reg_addr == REG_OV_ID) ? ov_id_r :
    (reg_addr == REG_OV_CNT) ? ov_cnt_r : 16'h0000;

  // register port
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl_r <= reg_wdata;
      end
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // error statistics; counters wrap
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sh_id_r <= 16'h0000;
      sh_cnt_r <= 16'h0000;
      un_id_r <= 16'h0000;
      un_cnt_r <= 16'h0000;
      ov_id_r <= 16'h0000;
      ov_cnt_r <= 16'h0000;
    end else begin
      if (err_hit != 5'h00) begin
        sh_cnt_r <= sh_cnt_r + 16'(err_n);
        sh_id_r <= vc_id;
      end
      if (state_r == ST_CHK && underrun) begin
        un_cnt_r <= un_cnt_r + 16'h0001;
        un_id_r <= vc_id;
      end
      if (state_r == ST_CHK && overrun) begin
        ov_cnt_r <= ov_cnt_r + 16'h0001;
        ov_id_r <= vc_id;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (state_r == ST_LOAD && mem_ack) begin
      sw_r[ld_idx_r] <= mem_rdata;
    end
  end

  // main sequencer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      vc_r <= 14'h0000;
      ld_idx_r <= 3'h0;
      k_r <= 7'h00;
      cur_r <= 8'h00;
      wp_r <= 10'h000;
      hdr_r <= 8'h00;
      hdr_seen_r <= 1'b0;
      pb_exp_r <= 1'b0;
      ent_r <= 16'h0000;
      wb_idx_r <= 1'b0;
      taddr_r <= 21'h000000;
      tue_r <= 1'b0;
      twd_r <= 1'b0;
      tbyte_r <= 9'h000;
      tdm_ack <= 1'b0;
      tdm_data <= 8'h00;
      tdm_underrun <= 1'b0;
    end else begin
      tdm_ack <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (tdm_req) begin
            taddr_r <= tdm_addr;
            tue_r <= tdm_underrun_en;
            twd_r <= tdm_wb_dis;
            state_r <= ST_TRD;
          end else if (f_valid && f_data.sop) begin
            vc_r <= f_data.vc_field;
            ld_idx_r <= 3'h0;
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (mem_ack) begin
            ld_idx_r <= ld_idx_r + 3'h1;
            if (ld_idx_r == 3'(STRUCT_WORDS - 1)) begin
              state_r <= ST_CHK;
            end
          end
        end
        ST_CHK: begin
          wp_r <= wp_start;
          cur_r <= sw_r[W_CUR][15:8];
          hdr_r <= sw_r[W_CUR][7:0];
          hdr_seen_r <= 1'b0;
          pb_exp_r <= 1'b0;
          k_r <= 7'h00;
          state_r <= ST_PAY;
        end
        ST_PAY: begin
          if (f_valid) begin
            if (at_hdr) begin
              hdr_r <= hb;
              hdr_seen_r <= 1'b1;
              pb_exp_r <= pb_follows;
            end
            if (in_payload) begin
              state_r <= ST_ENT;
            end else if (last_beat) begin
              wb_idx_r <= 1'b0;
              state_r <= ST_WB;
            end else begin
              k_r <= k_r + 7'h01;
            end
          end
        end
        ST_ENT: begin
          if (mem_ack) begin
            ent_r <= mem_rdata;
            state_r <= ST_BYTE;
          end
        end
        ST_BYTE: begin
          if (!ent_valid || mem_ack) begin
            // channels of one VC interleave byte by byte
            if (cur_r == last_ent) begin
              cur_r <= first_ent;
              wp_r <= (wp_r + 10'h001) & size_mask;
            end else begin
              cur_r <= cur_r + ENTRY_STEP;
            end
            if (last_beat) begin
              wb_idx_r <= 1'b0;
              state_r <= ST_WB;
            end else begin
              k_r <= k_r + 7'h01;
              state_r <= last_payload ? ST_PAY : ST_PAY;
            end
          end
        end
        ST_WB: begin
          if (mem_ack) begin
            wb_idx_r <= 1'b1;
            if (wb_idx_r) begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_TRD: begin
          if (mem_ack) begin
            tbyte_r <= mem_rdata[8:0];
            state_r <= ST_TWB;
          end
        end
        ST_TWB: begin
          if (mem_ack) begin
            tdm_ack <= 1'b1;
            tdm_data <= tbyte_r[7:0];
            tdm_underrun <= tue_r && tbyte_r[8];
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // aal_rx_reassembly_buffer_ctrl

`default_nettype wire

/* tb/mem_model.sv */
/*
  behavioural external memory: 16-bit words and 9-bit bytes.
  assumes the block holds each command until mem_ack.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import rx_reasm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire mem_cmd_type mem_cmd,
  input wire logic slow,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  output int word_writes
);
  logic [15:0] words [int];
  logic [8:0] bytes [int];
  logic [2:0] wait_r;
  logic flip_r = 1'b0;
  logic [15:0] val;
  wire logic [2:0] need = slow ? 3'h5 : 3'h0;
  assign mem_ack = mem_cmd.req && wait_r >= need;
  always_comb begin
    val = 16'h0000;
    if (mem_cmd.byte_access && bytes.exists(int'(mem_cmd.addr))) begin
      val = {7'h00, bytes[int'(mem_cmd.addr)]};
    end else if (!mem_cmd.byte_access && words.exists(int'(mem_cmd.addr))) begin
      val = words[int'(mem_cmd.addr)];
    end
  end
  // an idle bus shows a changing pattern, never the last value
  assign mem_rdata = (mem_ack && !mem_cmd.we) ? val : {16{flip_r}} ^ 16'h5A5A;
  always @(posedge clock) begin
    flip_r <= !flip_r;
    if (!rstn || !mem_cmd.req || mem_ack) wait_r <= 3'h0;
    else wait_r <= wait_r + 3'h1;
    if (!rstn) word_writes = 0;
    if (mem_ack && mem_cmd.we && mem_cmd.byte_access) bytes[int'(mem_cmd.addr)] = mem_cmd.wdata[8:0];
    if (mem_ack && mem_cmd.we && !mem_cmd.byte_access) begin
      words[int'(mem_cmd.addr)] = mem_cmd.wdata;
      word_writes = word_writes + 1;
    end
  end
endmodule // mem_model
`default_nettype wire

/* tb/rx_reasm_monitor.sv */
/*
  port assertions for the reassembly block.
  assumes one clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_reasm_monitor
  import rx_reasm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire mem_cmd_type mem_cmd,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic tdm_req,
  input wire logic tdm_underrun_en,
  input wire logic tdm_wb_dis,
  input wire logic tdm_ack,
  input wire logic [7:0] tdm_data,
  input wire logic tdm_underrun
);
  logic [15:0] ctrl_r;
  logic [8:0] rbyte_r;
  wire logic bwr = mem_cmd.req && mem_ack && mem_cmd.we && mem_cmd.byte_access;
  wire logic brd = mem_cmd.req && mem_ack && !mem_cmd.we && mem_cmd.byte_access;
  wire logic tdm_wb = bwr && tdm_req;
  wire logic mapped = reg_addr inside {REG_CTRL, REG_SH_ID, REG_SH_CNT, REG_UN_ID,
    REG_UN_CNT, REG_OV_ID, REG_OV_CNT};
  wire logic [8:0] wb_exp = {1'b1, tdm_wb_dis ? rbyte_r[7:0] : SILENCE};
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
      rbyte_r <= 9'h000;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) ctrl_r <= reg_wdata;
      if (brd) rbyte_r <= mem_rdata[8:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence wb_done;
    tdm_wb;
  endsequence
  a_unmapped_read_zero: assert property (
    reg_rd && !mapped |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_ctrl_read_back: assert property (
    reg_rd && reg_addr == REG_CTRL && !reg_wr |=> reg_rdata == ctrl_r) else $error("ctrl readback");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn |=> reg_rdata == 16'h0000 && !tdm_ack && !mem_cmd.req) else $error("reset outputs");
  a_word_aligned: assert property (
    mem_cmd.req && !mem_cmd.byte_access |-> mem_cmd.addr[0] == 1'b0) else $error("odd word");
  a_tdm_underrun_flag: assert property (
    tdm_ack |-> tdm_underrun == (rbyte_r[8] && tdm_underrun_en) && tdm_data == rbyte_r[7:0])
    else $error("tdm result");
  a_tdm_write_back: assert property (
    tdm_wb |-> mem_cmd.wdata[8:0] == wb_exp) else $error("tdm write-back value");
  a_tdm_ack_timing: assert property (
    wb_done |=> tdm_ack ##1 !tdm_ack) else $error("tdm ack timing");
  a_tdm_ack_cause: assert property (
    tdm_ack |-> $past(tdm_wb)) else $error("tdm ack without write-back");
  a_payload_bit_clear: assert property (
    bwr && !tdm_req |-> !mem_cmd.wdata[8]) else $error("payload ninth bit set");
endmodule // rx_reasm_monitor
bind aal_rx_reassembly_buffer_ctrl rx_reasm_monitor rx_reasm_monitor_inst (
  .clock, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mem_cmd,
  .mem_rdata, .mem_ack, .tdm_req, .tdm_underrun_en, .tdm_wb_dis, .tdm_ack,
  .tdm_data, .tdm_underrun
);
`default_nettype wire

/* tb/aal_rx_reassembly_buffer_ctrl_bench.sv */
/*
  bench: register, cell and tdm tasks against a memory model.
  assumes one 128-byte buffer on one vc; structure set up by direct memory writes.
*/
`timescale 1ns/1ps
`default_nettype none
module aal_rx_reassembly_buffer_ctrl_bench
  import rx_reasm_pkg::*;
();
  localparam logic [20:0] SP = 21'h040100;
  localparam logic [20:0] BUF = 21'h040000;
  localparam logic [13:0] FIELD = 14'h0010;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  cell_beat_type cell_in = '0;
  logic cell_valid = 1'b0;
  logic tdm_req = 1'b0;
  logic [20:0] tdm_addr = 21'h000000;
  logic tdm_underrun_en = 1'b0;
  logic tdm_wb_dis = 1'b0;
  logic slow = 1'b0;
  logic saw_full = 1'b0;
  logic [15:0] reg_rdata, mem_rdata;
  logic cell_ready, mem_ack, tdm_ack, tdm_underrun;
  logic [7:0] tdm_data;
  mem_cmd_type mem_cmd;
  int word_writes;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] regs_list [7] = '{REG_CTRL, REG_SH_ID, REG_SH_CNT, REG_UN_ID, REG_UN_CNT,
    REG_OV_ID, REG_OV_CNT};
  always #2.5 clock = ~clock;
  aal_rx_reassembly_buffer_ctrl #(.FIFO_DEPTH(32)) aal_rx_reassembly_buffer_ctrl_inst (
    .clock, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .cell_in,
    .cell_valid, .cell_ready, .mem_cmd, .mem_rdata, .mem_ack, .tdm_req, .tdm_addr,
    .tdm_underrun_en, .tdm_wb_dis, .tdm_ack, .tdm_data, .tdm_underrun
  );
  mem_model mem_model_inst (.clock, .rstn, .mem_cmd, .slow, .mem_rdata, .mem_ack, .word_writes);
  task automatic report_and_stop;
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check($sformatf("register %h", a), exp, reg_rdata);
  endtask
  task automatic setw(input int i, input logic [15:0] v);
    mem_model_inst.words[int'(SP) + 2 * i] = v;
  endtask
  // waits for the two closing word writes, bounded
  task automatic run_cell(input logic [7:0] b, input logic aal);
    int n;
    n = word_writes;
    for (int k = 0; k < 48; k++) begin
      cell_valid <= 1'b1;
      cell_in <= '{sop: k == 0, vc_field: FIELD, data: (aal && k == 0) ? 8'h01 : b + 8'(k)};
      @(posedge clock);
      while (cell_ready !== 1'b1) begin
        saw_full = 1'b1;
        @(posedge clock);
      end
    end
    cell_valid <= 1'b0;
    for (int i = 0; i < 4000 && word_writes < n + 2; i++) @(posedge clock);
    repeat (4) @(posedge clock);
  endtask
  task automatic check_bytes(input int start, input logic [7:0] b);
    for (int k = 0; k < 48; k++) begin
      check("buffer byte", {8'h00, b + 8'(k)},
        {7'h00, mem_model_inst.bytes[int'(BUF) + ((start + k) % 128)]});
    end
  endtask
  task automatic tdm_read(input int a, input logic en, wbd, input logic [7:0] d, input logic un);
    @(posedge clock);
    tdm_req <= 1'b1;
    tdm_addr <= 21'(a);
    tdm_underrun_en <= en;
    tdm_wb_dis <= wbd;
    for (int i = 0; i < 200 && !(mem_ack && mem_cmd.we); i++) @(posedge clock);
    // dropped on the write-back edge so the idle cycle does not serve it twice
    tdm_req <= 1'b0;
    #1 check("tdm ack", 16'h0001, {15'h0000, tdm_ack});
    check("tdm data", {8'h00, d}, {8'h00, tdm_data});
    check("tdm underrun", {15'h0000, un}, {15'h0000, tdm_underrun});
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 30000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    foreach (regs_list[i]) reg_read(regs_list[i], 16'h0000);
    reg_read(16'h3004, 16'h0000);
    reg_write(REG_CTRL, 16'h0001);
    reg_read(REG_CTRL, 16'h0001);
    setw(0, 16'h1010);
    setw(1, 16'h0208);
    setw(2, 16'h052F);
    setw(3, 16'h1000);
    setw(4, 16'h0000);
    setw(5, 16'h1000);
    setw(8, 16'h9000);
    run_cell(8'h00, 1'b0);
    check_bytes(20, 8'h00);
    check("state word", 16'h9044, mem_model_inst.words[int'(SP) + 10] & 16'hF07F);
    setw(4, 16'h0040);
    run_cell(8'h40, 1'b0);
    check_bytes(84, 8'h40);
    reg_read(REG_UN_CNT, 16'h0001);
    reg_read(REG_UN_ID, 16'h0010);
    reg_read(REG_OV_CNT, 16'h0000);
    setw(4, 16'h005C);
    slow <= 1'b1;
    run_cell(8'h80, 1'b0);
    slow <= 1'b0;
    check_bytes(112, 8'h80);
    check("fifo refused", 16'h0001, {15'h0000, saw_full});
    check("fifo drained", 16'h0001, {15'h0000, cell_ready});
    reg_read(REG_OV_CNT, 16'h0001);
    reg_read(REG_OV_ID, 16'h0010);
    setw(4, 16'h0010);
    run_cell(8'hC0, 1'b0);
    check_bytes(32, 8'hC0);
    reg_read(REG_UN_CNT, 16'h0001);
    mem_model_inst.bytes[int'(BUF) + 1] = 9'h15A;
    tdm_read(int'(BUF) + 1, 1'b1, 1'b0, 8'h5A, 1'b1);
    check("silence", 16'h01FF, {7'h00, mem_model_inst.bytes[int'(BUF) + 1]});
    tdm_read(int'(BUF) + 2, 1'b1, 1'b1, 8'h92, 1'b0);
    check("kept byte", 16'h0192, {7'h00, mem_model_inst.bytes[int'(BUF) + 2]});
    tdm_read(int'(BUF) + 1, 1'b0, 1'b0, 8'hFF, 1'b0);
    setw(2, 16'h05AF);
    setw(4, 16'h0040);
    run_cell(8'h10, 1'b1);
    reg_read(REG_SH_CNT, 16'h0000);
    reg_write(REG_CTRL, 16'h0011);
    run_cell(8'h20, 1'b1);
    reg_write(REG_SH_CNT, 16'hFFFF);
    reg_read(REG_SH_CNT, 16'h0001);
    reg_read(REG_SH_ID, 16'h0010);
    report_and_stop();
  end
endmodule // aal_rx_reassembly_buffer_ctrl_bench
`default_nettype wire
